// ==== hdl/vic_pkg.sv ====
// Constants shared by the vectored interrupt controller and its testbench.
// Assumes one 200 MHz system clock and a core that reaches the control registers through a select/write port.
package vic_pkg;

    // ==========================================================
    // Control register selects
    localparam logic [1:0] SEL_CTL_FIRST  = 2'h0;   // irq_control_first
    localparam logic [1:0] SEL_CTL_SECOND = 2'h1;   // irq_control_second
    localparam logic [1:0] SEL_SHV_FIRST  = 2'h2;   // shared_vector_control_first
    localparam logic [1:0] SEL_SHV_SECOND = 2'h3;   // shared_vector_control_second

    // ==========================================================
    // Implemented bits and reset values
    localparam logic [7:0] MASK_CTL_FIRST  = 8'h7f;
    localparam logic [7:0] MASK_CTL_SECOND = 8'h77;
    localparam logic [7:0] MASK_SHV_FIRST  = 8'hff;
    localparam logic [7:0] MASK_SHV_SECOND = 8'h77;
    localparam logic [7:0] RST_CTL         = 8'h00;

    // ==========================================================
    // Field positions
    localparam int BIT_GLOBAL   = 0;   // global_irq_enable in irq_control_first
    localparam int BIT_EN_LO    = 0;   // first enable bit of a dedicated pair
    localparam int BIT_FLAG_LO  = 4;   // first request flag bit of a register
    localparam int BIT_SHV_EN   = 0;   // shared_vector_control_first enables 3..0
    localparam int BIT_SHV_FLAG = 4;   // shared_vector_control_first flags 7..4

    // ==========================================================
    // Event inputs and vector slots
    localparam int NUM_EVENTS = 12;    // ext0 ext1 t0 t1 sim xp tb rtc adc spi1 t2 t3
    localparam int NUM_SLOTS  = 6;     // ext0 ext1 t0 t1 sim multi
    localparam logic [7:0] VEC_BASE = 8'h04;
    localparam logic [7:0] VEC_STEP = 8'h04;

    // ==========================================================
    // Timing, in instruction cycles after the sampling phase
    localparam logic [1:0] WAIT_NORMAL = 2'h1;
    localparam logic [1:0] WAIT_WAKE   = 2'h2;
    localparam int         CYCLE_DIV   = 4;    // system clocks per instruction cycle

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} vic_state_t;

endpackage : vic_pkg

// ==== hdl/vic_prio_enc.sv ====
// Fixed-priority encoder: the lowest index among the active requests wins.
// Assumes the caller has already gated each request with its enables.
module vic_prio_enc #(
    parameter int N = 6
) (
    input  wire logic [N-1:0]         req,
    output logic                      valid,
    output logic [$clog2(N)-1:0]      idx
);

    // ==========================================================
    // Elaboration check
    if (N < 2) begin : g_bad_n
        $error("vic_prio_enc needs at least two requests");
    end

    // ==========================================================
    // Search from the top so the lowest index is written last and wins
    always_comb begin
        valid = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                idx   = i[$clog2(N)-1:0];
            end
        end
    end

endmodule : vic_prio_enc

// ==== hdl/vic_ctrl.sv ====
// Vectored interrupt controller: request flags, enables, priority pick and the vector call towards the core.
// Assumes the core writes the four control registers through the select port and owns the program counter and stack.
// Overview of operation
// - Triggering event always sets its flag
// - Flag calls vector only when enabled
// - Global enable low blocks every call
// - Every source has its own enable bit
// - Call pushes next address, loads vector
// - Return instruction pops the saved address
// - Entering service clears global enable
// - Requests while blocked stay latched
// - Full stack withholds acknowledgement
// - Normal latency two or three cycles
// - Wake latency three or four cycles
// - Requests sampled on next second phase
// - Ext0 04, ext1 08, timer0 0C
// - Timer1 10, serial 14, rest 18
// - External beats internal when simultaneous
// - Any flag set wakes sleeping core
// - Serviced slot flag clears; sub-flags stay
// - Global enable bit0, resets to zero
module vic_ctrl
    import vic_pkg::*;
#(
    parameter int DIV = vic_pkg::CYCLE_DIV
) (
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    input  wire logic [vic_pkg::NUM_EVENTS-1:0] src_event,
    input  wire logic                          sfr_wr,
    input  wire logic [1:0]                    sfr_sel,
    input  wire logic [7:0]                    sfr_wdata,
    input  wire logic                          stack_full,
    input  wire logic                          return_from_interrupt_exec,
    input  wire logic                          core_asleep,
    output logic [7:0]                         irq_control_first,
    output logic [7:0]                         irq_control_second,
    output logic [7:0]                         shared_vector_control_first,
    output logic [7:0]                         shared_vector_control_second,
    output logic                               second_clock_phase,
    output logic                               stack_push,
    output logic                               pc_load,
    output logic [7:0]                         pc_load_value,
    output logic                               stack_pop,
    output logic                               wake_req
);
    import vic_pkg::*;

    // ==========================================================
    // Elaboration check
    if (DIV < 2 || DIV > 255) begin : g_bad_div
        $error("vic_ctrl DIV must lie in 2..255");
    end

    // ==========================================================
    // Declarations
    logic [7:0]           cf_r, cs_r, sf_r, ss_r;
    logic [7:0]           cf_nxt, cs_nxt, sf_nxt, ss_nxt;
    logic [7:0]           set_cf, set_cs, set_sf, set_ss;
    logic [7:0]           clr_cf, clr_cs;
    logic [7:0]           div_r;
    logic                 phase;
    logic                 mf_set;
    logic [NUM_SLOTS-1:0] pend;
    logic                 pick_valid;
    logic [2:0]           pick_idx;
    logic [2:0]           slot_r;
    logic [1:0]           wait_r;
    vic_state_t           st_r;
    logic                 take_now;
    logic                 jump_r;
    logic [7:0]           vec_r;
    logic                 pop_r;
    logic                 wake_r;
    logic                 allowed;

    // Vector address of a slot: 04H for the first, stepping by four
    function automatic logic [7:0] slot_vector(input logic [2:0] s);
        slot_vector = 8'(VEC_BASE + 8'(s) * VEC_STEP);
    endfunction : slot_vector

    // Register value after a write of the core, masked to implemented bits
    function automatic logic [7:0] wr_val(input logic [7:0] cur, input logic hit,
                                          input logic [7:0] d, input logic [7:0] m);
        wr_val = hit ? (d & m) : cur;
    endfunction : wr_val

    // ==========================================================
    // Instruction cycle divider: one pulse per cycle marks the sampling phase
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_r <= 8'h00;
        end else if (div_r == 8'(DIV - 1)) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end
    assign phase              = (div_r == 8'(DIV - 1));
    assign second_clock_phase = phase;

    // ==========================================================
    // Flag set terms; shared sources only raise the multi flag when enabled
    assign mf_set = |({src_event[5], src_event[6], src_event[7], src_event[8]} & sf_r[3:0])
                  | |({src_event[11], src_event[10], src_event[9]} & ss_r[2:0]);
    assign set_cf = {1'b0, src_event[2], src_event[1], src_event[0], 4'h0};
    assign set_cs = {1'b0, mf_set, src_event[4], src_event[3], 4'h0};
    assign set_sf = {src_event[5], src_event[6], src_event[7], src_event[8], 4'h0};
    assign set_ss = {1'b0, src_event[11], src_event[10], src_event[9], 4'h0};

    // Clear terms at vector entry: serviced flag and the global enable
    always_comb begin
        clr_cf = 8'h00;
        clr_cs = 8'h00;
        if (take_now) begin
            clr_cf[BIT_GLOBAL] = 1'b1;
            if (slot_r < 3'd3) begin
                clr_cf[BIT_FLAG_LO + 32'(slot_r)] = 1'b1;
            end else begin
                clr_cs[BIT_FLAG_LO + 32'(slot_r) - 3] = 1'b1;
            end
        end
    end

    // Set wins over both the core write and the service clear, so no event is lost
    assign cf_nxt = (wr_val(cf_r, sfr_wr && sfr_sel == SEL_CTL_FIRST, sfr_wdata, MASK_CTL_FIRST)
                    & ~clr_cf) | set_cf;
    assign cs_nxt = (wr_val(cs_r, sfr_wr && sfr_sel == SEL_CTL_SECOND, sfr_wdata, MASK_CTL_SECOND)
                    & ~clr_cs) | set_cs;
    assign sf_nxt = wr_val(sf_r, sfr_wr && sfr_sel == SEL_SHV_FIRST, sfr_wdata, MASK_SHV_FIRST) | set_sf;
    assign ss_nxt = wr_val(ss_r, sfr_wr && sfr_sel == SEL_SHV_SECOND, sfr_wdata, MASK_SHV_SECOND) | set_ss;

    // Control registers; everything off after reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cf_r <= RST_CTL;
            cs_r <= RST_CTL;
            sf_r <= RST_CTL;
            ss_r <= RST_CTL;
        end else begin
            cf_r <= cf_nxt;
            cs_r <= cs_nxt;
            sf_r <= sf_nxt;
            ss_r <= ss_nxt;
        end
    end
    assign irq_control_first            = cf_r;
    assign irq_control_second           = cs_r;
    assign shared_vector_control_first  = sf_r;
    assign shared_vector_control_second = ss_r;

    // ==========================================================
    // Enabled pending requests per vector slot, in priority order
    assign pend[0] = cf_r[BIT_FLAG_LO]     & cf_r[BIT_EN_LO + 1];
    assign pend[1] = cf_r[BIT_FLAG_LO + 1] & cf_r[BIT_EN_LO + 2];
    assign pend[2] = cf_r[BIT_FLAG_LO + 2] & cf_r[BIT_EN_LO + 3];
    assign pend[3] = cs_r[BIT_FLAG_LO]     & cs_r[BIT_EN_LO];
    assign pend[4] = cs_r[BIT_FLAG_LO + 1] & cs_r[BIT_EN_LO + 1];
    assign pend[5] = cs_r[BIT_FLAG_LO + 2] & cs_r[BIT_EN_LO + 2];

    // Lowest slot wins, so external pins come before every internal source
    vic_prio_enc #(
        .N (NUM_SLOTS)
    ) u_prio (
        .req   (pend),
        .valid (pick_valid),
        .idx   (pick_idx)
    );

    // Global enable and a free stack slot both gate acknowledgement
    assign allowed  = cf_r[BIT_GLOBAL] && !stack_full;
    assign take_now = (st_r == ST_WAIT) && phase && (wait_r == 2'h1) && allowed && pend[slot_r];

    // ==========================================================
    // Sequencer: sample on a phase pulse, call the vector one or two cycles later
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r   <= ST_IDLE;
            slot_r <= 3'h0;
            wait_r <= 2'h0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (phase && allowed && pick_valid) begin
                        st_r   <= ST_WAIT;
                        slot_r <= pick_idx;
                        wait_r <= core_asleep ? WAIT_WAKE : WAIT_NORMAL;
                    end
                end
                ST_WAIT: begin
                    if (phase) begin
                        if (wait_r != 2'h1) begin
                            wait_r <= wait_r - 2'h1;
                        end else if (take_now || !pend[slot_r] || !cf_r[BIT_GLOBAL]) begin
                            st_r <= ST_IDLE;                                           // Done or withdrawn
                        end
                        // A full stack keeps the request waiting here
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Vector call towards the core; push and load share one pulse
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            jump_r <= 1'b0;
            vec_r  <= 8'h00;
        end else begin
            jump_r <= take_now;
            if (take_now) begin
                vec_r <= slot_vector(slot_r);
            end
        end
    end
    assign stack_push    = jump_r;
    assign pc_load       = jump_r;
    assign pc_load_value = vec_r;

    // Return and wake pulses; wake only means something while the core sleeps
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pop_r  <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            pop_r  <= return_from_interrupt_exec;
            wake_r <= core_asleep && (|(set_cf & ~cf_r) || |(set_cs & ~cs_r)
                      || |(set_sf & ~sf_r) || |(set_ss & ~ss_r));
        end
    end
    assign stack_pop = pop_r;
    assign wake_req  = wake_r;

    // ==========================================================
    // Assertions
    // Entry and gating: the call itself must leave the controller blocked
    glob_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
        jump_r |-> !cf_r[BIT_GLOBAL])
        else $error("global enable still set after vector entry");
    glob_block_a: assert property (@(posedge sys_clk) disable iff (srst)
        jump_r |-> $past(cf_r[BIT_GLOBAL]))
        else $error("vector call with global enable low");
    stack_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        jump_r |-> !$past(stack_full))
        else $error("vector call while stack full");
    ext0_vec_a: assert property (@(posedge sys_clk) disable iff (srst)
        (jump_r && pc_load_value == 8'h04) |-> $past(cf_r[BIT_EN_LO + 1]))
        else $error("ext0 vector taken while disabled");
    vec_range_a: assert property (@(posedge sys_clk) disable iff (srst)
        jump_r |-> (pc_load_value inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18}))
        else $error("vector address outside table");
    // Flags: set always wins, service clears only the winner; reset clears the registers, return pops the stack
    flag_set_a: assert property (@(posedge sys_clk) disable iff (srst)
        src_event[0] |=> cf_r[BIT_FLAG_LO])
        else $error("ext0 event did not set its flag");
    held_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        (src_event[1] && !cf_r[BIT_GLOBAL]) |=> cf_r[BIT_FLAG_LO + 1])
        else $error("blocked ext1 request was not latched");
    flag_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
        (take_now && slot_r == 3'h0 && !src_event[0]) |=> !cf_r[BIT_FLAG_LO])
        else $error("serviced ext0 flag not cleared");
    rst_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(srst) |-> (cf_r == RST_CTL && cs_r == RST_CTL && sf_r == RST_CTL && ss_r == RST_CTL))
        else $error("control registers not cleared by reset");
    ret_pop_a: assert property (@(posedge sys_clk) disable iff (srst)
        return_from_interrupt_exec |=> stack_pop)
        else $error("return did not pop the stack");
    // Timing: sampling only on phase pulses, which never come back to back
    jump_phase_a: assert property (@(posedge sys_clk) disable iff (srst)
        jump_r |-> $past(phase) && $past(st_r == ST_WAIT))
        else $error("vector call off the sampling phase");
    phase_gap_a: assert property (@(posedge sys_clk) disable iff (srst)
        phase |=> !phase)
        else $error("sampling phase lasted more than one clock");
    wake_wait_a: assert property (@(posedge sys_clk) disable iff (srst)
        (st_r == ST_IDLE && phase && allowed && pick_valid && core_asleep) |=> wait_r == WAIT_WAKE)
        else $error("request captured asleep without the wake delay");
    // Priority is judged at capture; a request arriving after sampling waits its turn; a new flag wakes a sleeping core
    ext_first_a: assert property (@(posedge sys_clk) disable iff (srst)
        (st_r == ST_IDLE && phase && allowed && pend[0]) |=> slot_r == 3'h0)
        else $error("external request lost its priority");
    wake_a: assert property (@(posedge sys_clk) disable iff (srst)
        (core_asleep && src_event[0] && !cf_r[BIT_FLAG_LO]) |=> wake_req)
        else $error("flag set did not wake the core");

    call_c:   cover property (@(posedge sys_clk) disable iff (srst) jump_r);
    multi_c:  cover property (@(posedge sys_clk) disable iff (srst) jump_r && pc_load_value == 8'h18);
    held_c:   cover property (@(posedge sys_clk) disable iff (srst) st_r == ST_WAIT && phase && stack_full);
    wakeup_c: cover property (@(posedge sys_clk) disable iff (srst) wake_req ##[1:40] jump_r);

endmodule : vic_ctrl

// ==== bench/vic_core_model.sv ====
// Core model: program counter and hardware stack driven by the interrupt controller.
// Assumes one-clock push, load and pop pulses; the bench requests returns through ret_go.
module vic_core_model #(
    parameter int DEPTH = 2
) (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       ret_go,
    input  wire logic       stack_push,
    input  wire logic       pc_load,
    input  wire logic [7:0] pc_load_value,
    input  wire logic       stack_pop,
    output logic            stack_full,
    output logic            return_from_interrupt_exec,
    output logic [7:0]      pc_r,
    output logic [3:0]      depth_r
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] stk_r [0:DEPTH-1];

    // ==========================================================
    // Stack state
    // Full while every slot holds an address, so calls must wait
    assign stack_full = (depth_r == 4'(DEPTH));

    // A return is only issued while something is stacked
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            return_from_interrupt_exec <= 1'b0;
        end else begin
            return_from_interrupt_exec <= ret_go && (depth_r != 4'h0);
        end
    end

    // Push saves the running address, load jumps, pop restores it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pc_r    <= 8'h40;
            depth_r <= 4'h0;
        end else begin
            if (stack_push && !stack_full) begin
                stk_r[int'(depth_r)] <= pc_r;
                depth_r              <= depth_r + 4'h1;
            end
            if (pc_load) begin
                pc_r <= pc_load_value;
            end
            if (stack_pop && depth_r != 4'h0) begin
                pc_r    <= stk_r[int'(depth_r) - 1];
                depth_r <= depth_r - 4'h1;
            end
        end
    end
endmodule : vic_core_model

// ==== bench/vectored_interrupt_controller_tb.sv ====
// Self-checking bench for the vectored interrupt controller with a core model.
// Assumes a 200 MHz clock and a short instruction-cycle divider to keep waits small.
module vectored_interrupt_controller_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vic_pkg::*;
    localparam int DV = 4;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic [11:0] src_event = 12'h000;
    logic        sfr_wr = 1'b0;
    logic [1:0]  sfr_sel = 2'h0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        core_asleep = 1'b0;
    logic        ret_go = 1'b0;
    logic        stack_full, return_from_interrupt_exec, second_clock_phase, stack_push, pc_load, stack_pop, wake_req;
    logic [7:0]  irq_control_first, irq_control_second, shared_vector_control_first;
    logic [7:0]  shared_vector_control_second, pc_load_value, pc_r;
    logic [3:0]  depth_r;
    logic [7:0]  vec_tbl [0:5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    int          miscompares = 0;
    int          comparisons = 0;

    // ==========================================================
    // Clock, design and core model
    always #2.5 sys_clk = ~sys_clk;
    vic_ctrl #(.DIV(DV)) DUT (.sys_clk, .srst, .src_event, .sfr_wr, .sfr_sel, .sfr_wdata, .stack_full,
        .return_from_interrupt_exec, .core_asleep, .irq_control_first, .irq_control_second, .shared_vector_control_first,
        .shared_vector_control_second, .second_clock_phase, .stack_push, .pc_load, .pc_load_value,
        .stack_pop, .wake_req);
    vic_core_model #(.DEPTH(2)) core_u (.sys_clk, .srst, .ret_go, .stack_push, .pc_load, .pc_load_value,
        .stack_pop, .stack_full, .return_from_interrupt_exec, .pc_r, .depth_r);

    // ==========================================================
    // Helpers
    task automatic wrap_up();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic cmp8(input string w, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask : cmp8

    task automatic cmp_in(input string w, input int lo, input int hi, input int n);
        comparisons++;
        if (n < lo || n > hi) begin
            miscompares++;
            $display("[ERR] %s expected %0d..%0d seen %0d", w, lo, hi, n);
        end
    endtask : cmp_in

    task automatic wr(input int sel, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_wr = 1'b1;
        sfr_sel = 2'(sel);
        sfr_wdata = d;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask : wr

    // One-cycle event pulse; returns where the new flags are visible
    task automatic ev(input logic [11:0] m);
        @(negedge sys_clk);
        src_event = m;
        @(negedge sys_clk);
        src_event = 12'h000;
    endtask : ev

    // Bounded wait for a vector call; a miss ends the run
    task automatic wait_call(input int lim, output int n);
        n = 0;
        while (pc_load !== 1'b1 && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        cmp8("pc_load", 8'h01, {7'h0, pc_load});
        cmp8("stack_push", 8'h01, {7'h0, stack_push});
        if (pc_load !== 1'b1) wrap_up();
    endtask : wait_call

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge sys_clk);
            if (pc_load !== 1'b0) seen = 1'b1;
        end
        cmp8("pc_load quiet", 8'h00, {7'h0, seen});
    endtask : quiet

    task automatic ret();
        @(negedge sys_clk);
        ret_go = 1'b1;
        @(negedge sys_clk);
        ret_go = 1'b0;
        @(negedge sys_clk);
        cmp8("stack_pop", 8'h01, {7'h0, stack_pop});
    endtask : ret

    task automatic clr();
        for (int i = 0; i < 4; i++) wr(i, 8'h00);
    endtask : clr

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        int p;
        cmp8("irq_control_first", 8'h00, irq_control_first);
        cmp8("irq_control_second", 8'h00, irq_control_second);
        cmp8("shared_vector_control_first", 8'h00, shared_vector_control_first);
        cmp8("shared_vector_control_second", 8'h00, shared_vector_control_second);
        // One sampling pulse per instruction cycle of DV clocks
        p = 0;
        repeat (4 * DV) begin
            @(negedge sys_clk);
            if (second_clock_phase === 1'b1) p++;
        end
        cmp_in("second_clock_phase pulses", 4, 4, p);
        $display("reset test done");
    endtask : t_reset

    task automatic t_gate();
        int n;
        ev(12'h001);
        cmp8("irq_control_first", 8'h10, irq_control_first);
        wr(0, 8'h12);
        quiet(8 * DV);
        wr(0, 8'h11);
        quiet(8 * DV);
        wr(0, 8'h17);
        wait_call(40, n);
        cmp8("pc_load_value", 8'h04, pc_load_value);
        cmp8("irq_control_first", 8'h06, irq_control_first);
        @(negedge sys_clk);
        cmp8("core pc", 8'h04, pc_r);
        ev(12'h002);
        cmp8("irq_control_first", 8'h26, irq_control_first);
        quiet(8 * DV);
        ret();
        @(negedge sys_clk);
        cmp8("core pc", 8'h40, pc_r);
        wr(0, 8'h27);
        wait_call(40, n);
        cmp8("pc_load_value", 8'h08, pc_load_value);
        ret();
        $display("gating test done");
    endtask : t_gate

    task automatic t_prio();
        int n;
        clr();
        wr(0, 8'h0e);
        wr(1, 8'h07);
        wr(2, 8'h0f);
        ev(12'h11f);
        cmp8("irq_control_first", 8'h7e, irq_control_first);
        cmp8("irq_control_second", 8'h77, irq_control_second);
        for (int k = 0; k < 6; k++) begin
            wr(0, irq_control_first | 8'h01);
            wait_call(40, n);
            cmp8("pc_load_value", vec_tbl[k], pc_load_value);
            ret();
        end
        $display("priority test done");
    endtask : t_prio

    task automatic t_shared();
        int n;
        int b;
        logic [15:0] sub;
        clr();
        wr(1, 8'h04);
        for (int e = 5; e < 12; e++) begin
            wr(2, 8'h0f);
            wr(3, 8'h07);
            ev(12'h001 << e);
            sub = {shared_vector_control_second, shared_vector_control_first};
            b = (e < 9) ? 12 - e : e + 3;
            cmp8("shared sub-flag", 8'h01, {7'h0, sub[b]});
            wr(0, 8'h01);
            wait_call(40, n);
            cmp8("pc_load_value", 8'h18, pc_load_value);
            ret();
        end
        $display("shared vector test done");
    endtask : t_shared

    task automatic t_stack();
        int n;
        clr();
        wr(0, 8'h03);
        ev(12'h001);
        wait_call(40, n);
        cmp_in("request latency", DV + 1, 3 * DV, n + 1);
        wr(0, 8'h03); // Handler re-enables to allow nesting
        ev(12'h001);
        wait_call(40, n);
        wr(0, 8'h03);
        ev(12'h001);
        cmp8("stack depth", 8'h02, {4'h0, depth_r});
        quiet(8 * DV);
        cmp8("irq_control_first", 8'h13, irq_control_first);
        ret();
        wait_call(40, n);
        cmp8("pc_load_value", 8'h04, pc_load_value);
        ret();
        ret();
        $display("stack test done");
    endtask : t_stack

    task automatic t_wake();
        int n;
        clr();
        wr(0, 8'h03);
        core_asleep = 1'b1;
        ev(12'h001);
        cmp8("wake_req", 8'h01, {7'h0, wake_req});
        wait_call(60, n);
        cmp_in("wake latency", 2 * DV + 1, 4 * DV, n + 1);
        core_asleep = 1'b0;
        ret();
        wr(0, 8'h02);
        ev(12'h001); // Flag preset before sleeping
        core_asleep = 1'b1;
        ev(12'h001);
        cmp8("wake_req", 8'h00, {7'h0, wake_req});
        core_asleep = 1'b0;
        $display("wake test done");
    endtask : t_wake

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(negedge sys_clk);
        srst = 1'b0;
        @(negedge sys_clk);
        t_reset();
        t_gate();
        t_prio();
        t_shared();
        t_stack();
        t_wake();
        wrap_up();
    end
endmodule : vectored_interrupt_controller_tb
